// file: src/fieldbus_status_indicators.sv
// status indicators and link-role logic for the fieldbus slave interface
// Contract
// (R1) run indicator: off in off/init, 200 ms blink preop, single flash safeop, 50 ms blink booting, solid op.
// (R2) refused state change blinks the fault indicator at 200 ms.
// (R3) internal-fault state change gives repeating single red flashes.
// (R4) sync channel watchdog expiry gives repeating double red flashes.
// (R5) start-up error blinks the fault indicator at 50 ms, otherwise it is off when no error.
// (R6) each port indicator is off when down, solid when up, 50 ms blink while receiving.
// (R7) first port faces the master or upstream, second port faces downstream.
// (R8) each port runs at 100 Mbps full duplex.
// (R9) process data is cyclic at whatever period the master sets.
// (R10) service data uses acyclic mailbox exchange apart from the cyclic path.
// (R11) the device runs free-run with a 4 ms local application cycle.
// (R12) all patterns share one timebase and flash groups repeat after a fixed pause; code repeats every 2000 ms, pausing 1800 ms single, 1400 ms double.
// (R13) several errors show one pattern by priority startup, watchdog, internal, refused.
`timescale 1ns/1ns
`default_nettype none
module fieldbus_status_indicators #(
   parameter int unsigned TICK_CYCLES = status_ind_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // slave state and errors
   input  wire logic [2:0] slaveState,
   input  wire logic       refusedTransition,
   input  wire logic       internalFault,
   input  wire logic       watchdogExpired,
   input  wire logic       startupError,
   // port status, upstream then downstream
   input  wire logic       upLinkUp,
   input  wire logic       upRxActive,
   input  wire logic       downLinkUp,
   input  wire logic       downRxActive,
   // cyclic and mailbox strobes from the master
   input  wire logic       cyclicFrame,
   input  wire logic       mailboxFrame,
   // indicators
   output logic            runInd,
   output logic            faultInd,
   output logic            upLinkInd,
   output logic            downLinkInd,
   // link role and configuration
   output logic [1:0]      portSpeed,
   output logic            portFullDuplex,
   output logic            upIsMasterSide,
   // data paths
   output logic            cyclicUpdate,
   output logic            mailboxService,
   output logic            appCycleTick
);
   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rstMeta_b;
   logic rstSync_b;

   // rest of the design leaves reset two edges after rst_b rises
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_b <= 1'b0;
         rstSync_b <= 1'b0;
      end else begin
         rstMeta_b <= 1'b1;
         rstSync_b <= rstMeta_b;
      end
   end

   // ----------------------------------------
   // timebase
   // ----------------------------------------
   logic msTick;
   logic slowBlink;
   logic fastBlink;
   logic flashOne;
   logic flashTwo;
   logic appCycle;

   // patterns use the phase outputs only, the raw tick stays inside
   blink_timebase #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timebase (
      .ref_clk   (ref_clk),
      .rstSync_b (rstSync_b),
      .msTick    (),
      .slowBlink (slowBlink),
      .fastBlink (fastBlink),
      .flashOne  (flashOne),
      .flashTwo  (flashTwo),
      .appCycle  (appCycle)
   ); // R12

   // ----------------------------------------
   // fault pattern selection
   // ----------------------------------------
   status_ind_pkg::fault_pat_t faultPat;
   status_ind_pkg::fault_pat_t next_faultPat;

   always_comb begin
      if (startupError) begin
         next_faultPat = status_ind_pkg::FLT_STARTUP; // R13
      end else if (watchdogExpired) begin
         next_faultPat = status_ind_pkg::FLT_WATCHDOG;
      end else if (internalFault) begin
         next_faultPat = status_ind_pkg::FLT_INTERNAL;
      end else if (refusedTransition) begin
         next_faultPat = status_ind_pkg::FLT_REFUSED;
      end else begin
         next_faultPat = status_ind_pkg::FLT_NONE;
      end
   end

   // pattern choice held one cycle, indicator lags the errors by two edges
   always_ff @(posedge ref_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         faultPat <= status_ind_pkg::FLT_NONE;
      end else begin
         faultPat <= next_faultPat;
      end
   end

   // ----------------------------------------
   // indicator next values
   // ----------------------------------------
   logic next_runInd;
   logic next_faultInd;
   logic next_upLinkInd;
   logic next_downLinkInd;

   function automatic logic port_led(input logic up, input logic rx, input logic blink);
      port_led = up && (rx ? blink : 1'b1);
   endfunction

   always_comb begin
      case (status_ind_pkg::slave_state_t'(slaveState))
         status_ind_pkg::SLV_PREOP:   next_runInd = slowBlink; // R1
         status_ind_pkg::SLV_SAFEOP:  next_runInd = flashOne; // R1
         status_ind_pkg::SLV_BOOTING: next_runInd = fastBlink; // R1
         status_ind_pkg::SLV_OP:      next_runInd = 1'b1; // R1
         default:                     next_runInd = 1'b0; // R1
      endcase
      case (faultPat)
         status_ind_pkg::FLT_STARTUP:  next_faultInd = fastBlink; // R5
         status_ind_pkg::FLT_WATCHDOG: next_faultInd = flashTwo; // R4
         status_ind_pkg::FLT_INTERNAL: next_faultInd = flashOne; // R3
         status_ind_pkg::FLT_REFUSED:  next_faultInd = slowBlink; // R2
         default:                      next_faultInd = 1'b0; // R5
      endcase
      next_upLinkInd   = port_led(upLinkUp, upRxActive, fastBlink); // R6
      next_downLinkInd = port_led(downLinkUp, downRxActive, fastBlink); // R6
   end

   // ----------------------------------------
   // indicator registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         runInd      <= 1'b0;
         faultInd    <= 1'b0;
         upLinkInd   <= 1'b0;
         downLinkInd <= 1'b0;
      end else begin
         runInd      <= next_runInd;
         faultInd    <= next_faultInd;
         upLinkInd   <= next_upLinkInd;
         downLinkInd <= next_downLinkInd;
      end
   end

   // ----------------------------------------
   // link role and configuration
   // ----------------------------------------
   logic [1:0] next_portSpeed;
   logic       next_portFullDuplex;
   logic       next_upIsMasterSide;

   // fixed after reset, no negotiation
   always_comb begin
      next_portSpeed      = status_ind_pkg::LINK_SPEED_100M; // R8
      next_portFullDuplex = status_ind_pkg::LINK_FULL_DUP; // R8
      next_upIsMasterSide = 1'b1; // R7
   end

   always_ff @(posedge ref_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         portSpeed      <= 2'h0;
         portFullDuplex <= 1'b0;
         upIsMasterSide <= 1'b0;
      end else begin
         portSpeed      <= next_portSpeed;
         portFullDuplex <= next_portFullDuplex;
         upIsMasterSide <= next_upIsMasterSide;
      end
   end

   // ----------------------------------------
   // cyclic, mailbox and application strobes
   // ----------------------------------------
   logic next_cyclicUpdate;
   logic next_mailboxService;
   logic next_appCycleTick;

   // a mailbox frame beside a cyclic frame is dropped,
   // so the acyclic path never runs in the cyclic slot
   always_comb begin
      next_cyclicUpdate   = cyclicFrame; // R9
      next_mailboxService = mailboxFrame && !cyclicFrame; // R10
      next_appCycleTick   = appCycle; // R11
   end

   always_ff @(posedge ref_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         cyclicUpdate   <= 1'b0;
         mailboxService <= 1'b0;
         appCycleTick   <= 1'b0;
      end else begin
         cyclicUpdate   <= next_cyclicUpdate;
         mailboxService <= next_mailboxService;
         appCycleTick   <= next_appCycleTick;
      end
   end
endmodule
`default_nettype wire

// file: include/status_ind_pkg.sv
// constants and types for the fieldbus status indicator block
package status_ind_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned TICK_US         = 1_000;
   localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;
   localparam int unsigned SLOW_BLINK_MS   = 200;
   localparam int unsigned FAST_BLINK_MS   = 50;
   localparam int unsigned FLASH_ON_MS     = 200;
   localparam int unsigned FLASH_PAUSE_MS  = 1_000;
   localparam int unsigned APP_CYCLE_MS    = 4;
   localparam int unsigned SEQ_MS          = 2_000;

   // ----------------------------------------
   // slave state machine codes
   // ----------------------------------------
   typedef enum logic [2:0] {
      SLV_OFF     = 3'h0,
      SLV_INIT    = 3'h1,
      SLV_PREOP   = 3'h2,
      SLV_SAFEOP  = 3'h3,
      SLV_OP      = 3'h4,
      SLV_BOOTING = 3'h5
   } slave_state_t;

   // ----------------------------------------
   // fault indicator pattern, one-hot
   // ----------------------------------------
   typedef enum logic [4:0] {
      FLT_NONE     = 5'h01,
      FLT_STARTUP  = 5'h02,
      FLT_WATCHDOG = 5'h04,
      FLT_INTERNAL = 5'h08,
      FLT_REFUSED  = 5'h10
   } fault_pat_t;

   // ----------------------------------------
   // link properties
   // ----------------------------------------
   localparam logic [1:0] LINK_SPEED_100M = 2'h1;
   localparam logic       LINK_FULL_DUP   = 1'h1;
endpackage

// file: src/blink_timebase.sv
// shared millisecond timebase and blink/flash phase generator
`timescale 1ns/1ns
`default_nettype none
module blink_timebase #(
   parameter int unsigned TICK_CYCLES = status_ind_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rstSync_b,
   // phases
   output logic      msTick,
   output logic      slowBlink,
   output logic      fastBlink,
   output logic      flashOne,
   output logic      flashTwo,
   output logic      appCycle
);
   localparam int unsigned SEQ = status_ind_pkg::SEQ_MS;
   localparam int unsigned FON = status_ind_pkg::FLASH_ON_MS;

   logic [15:0] preCnt;
   logic [15:0] next_preCnt;
   logic [10:0] msCnt;
   logic [10:0] next_msCnt;
   logic        next_msTick;

   // ----------------------------------------
   // counters
   // ----------------------------------------
   always_comb begin
      next_msTick = (preCnt == 16'(TICK_CYCLES - 1));
      next_preCnt = next_msTick ? 16'h0000 : preCnt + 16'h0001;
      next_msCnt  = msCnt;
      if (next_msTick) begin
         next_msCnt = (msCnt == 11'(SEQ - 1)) ? 11'h000 : msCnt + 11'h001;
      end
   end

   always_ff @(posedge ref_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         preCnt <= 16'h0000;
         msCnt  <= 11'h000;
         msTick <= 1'b0;
      end else begin
         preCnt <= next_preCnt;
         msCnt  <= next_msCnt;
         msTick <= next_msTick;
      end
   end

   // ----------------------------------------
   // phases: blinks on for the first half of each period, flashes at the start of each sequence
   // ----------------------------------------
   always_comb begin
      slowBlink = ((msCnt % 11'(2 * status_ind_pkg::SLOW_BLINK_MS))
                   < 11'(status_ind_pkg::SLOW_BLINK_MS));
      fastBlink = ((msCnt % 11'(2 * status_ind_pkg::FAST_BLINK_MS))
                   < 11'(status_ind_pkg::FAST_BLINK_MS));
      flashOne  = (msCnt < 11'(FON));
      flashTwo  = (msCnt < 11'(FON)) || ((msCnt >= 11'(2 * FON)) && (msCnt < 11'(3 * FON)));
      appCycle  = msTick && ((msCnt % 11'(status_ind_pkg::APP_CYCLE_MS)) == 11'h000);
   end
endmodule
`default_nettype wire

// file: tb/fieldbus_status_indicators_monitor.sv
// checker for the fieldbus status indicators
`timescale 1ns/1ns
`default_nettype none
module fieldbus_status_indicators_monitor #(
   parameter int unsigned TICK_CYCLES = 10
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // observed signals
   input  wire logic       upLinkUp,
   input  wire logic       downLinkUp,
   input  wire logic       cyclicFrame,
   input  wire logic       mailboxFrame,
   input  wire logic       upLinkInd,
   input  wire logic       downLinkInd,
   input  wire logic [1:0] portSpeed,
   input  wire logic       cyclicUpdate,
   input  wire logic       mailboxService,
   input  wire logic       appCycleTick
);
   localparam int unsigned PER = status_ind_pkg::APP_CYCLE_MS * TICK_CYCLES;
   logic [31:0] since;
   logic [31:0] next_since;
   logic        seen;
   logic        next_seen;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence s_mbxOnly;
      mailboxFrame && !cyclicFrame;
   endsequence
   always_comb begin
      next_since = appCycleTick ? 32'h0 : since + 32'h1;
      next_seen  = seen | appCycleTick;
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         since <= 32'h0;
         seen  <= 1'b0;
      end else begin
         since <= next_since;
         seen  <= next_seen;
      end
   end
   a_cyclic_echo: assert property (cyclicFrame |=> cyclicUpdate)
      else $error("cyclic frame not passed on");
   a_cyclic_cause: assert property (cyclicUpdate |-> $past(cyclicFrame))
      else $error("cyclic update without frame");
   a_mbx_echo: assert property (s_mbxOnly |=> mailboxService)
      else $error("mailbox frame not served");
   a_mbx_apart: assert property (mailboxService |-> $past(mailboxFrame) && !$past(cyclicFrame))
      else $error("mailbox served beside cyclic");
   a_up_dark: assert property (!upLinkUp |=> !upLinkInd)
      else $error("upstream indicator lit while down");
   a_down_dark: assert property (!downLinkUp |=> !downLinkInd)
      else $error("downstream indicator lit while down");
   a_app_period: assert property (seen && appCycleTick |-> since == PER - 1)
      else $error("application cycle spacing wrong");
   a_link_speed: assert property (rst_b [*4] |-> portSpeed == status_ind_pkg::LINK_SPEED_100M)
      else $error("port speed wrong");
endmodule
bind fieldbus_status_indicators fieldbus_status_indicators_monitor #(
   .TICK_CYCLES(TICK_CYCLES)
) u_mon (
   .ref_clk(ref_clk), .rst_b(rst_b), .upLinkUp(upLinkUp), .downLinkUp(downLinkUp),
   .cyclicFrame(cyclicFrame), .mailboxFrame(mailboxFrame), .upLinkInd(upLinkInd),
   .downLinkInd(downLinkInd), .portSpeed(portSpeed), .cyclicUpdate(cyclicUpdate),
   .mailboxService(mailboxService), .appCycleTick(appCycleTick)
);
`default_nettype wire

// file: tb/master_station_model.sv
// master station model sending cyclic and mailbox frames
`timescale 1ns/1ns
`default_nettype none
module master_station_model (
   // clock and control
   input  wire logic       ref_clk,
   input  wire logic       runFrames,
   input  wire logic       collide,
   input  wire logic [3:0] period,
   // frame strobes
   output logic            cyclicFrame = 1'b0,
   output logic            mailboxFrame = 1'b0
);
   logic [3:0] cnt = 4'h0;
   always @(posedge ref_clk) begin
      cnt <= (runFrames && cnt < period - 4'h1) ? cnt + 4'h1 : 4'h0;
      cyclicFrame <= runFrames && cnt == 4'h0;
      mailboxFrame <= runFrames && (collide ? cnt == 4'h0 : cnt == 4'h1);
   end
endmodule
`default_nettype wire

// file: tb/tb_fieldbus_status_indicators.sv
// bench for the fieldbus status indicators
`timescale 1ns/1ns
`default_nettype none
module tb_fieldbus_status_indicators;
   localparam int TK = 2;
   localparam int W = 2000 * TK;
   logic ref_clk = 1'b0, rst_b = 1'b0, run = 1'b0, coll = 1'b0;
   logic [3:0] per = 4'h1, err = 4'h0, lnk = 4'h0;
   wire logic [3:0] obs;
   logic [2:0] st = 3'h0;
   logic       cF, mF, cU, mS, fd, ms, aT;
   logic [1:0] spd;
   int error_cnt = 0, check_count = 0;
   int pOn[6] = '{0, W, W / 2, W / 2, W / 10, W / 5};
   int pEd[6] = '{0, 0, 10, 40, 2, 4};
   always #50 ref_clk = ~ref_clk;
   master_station_model PM (.ref_clk(ref_clk), .runFrames(run), .collide(coll),
      .period(per), .cyclicFrame(cF), .mailboxFrame(mF));
   fieldbus_status_indicators #(.TICK_CYCLES(TK)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
      .slaveState(st), .refusedTransition(err[0]), .internalFault(err[1]),
      .watchdogExpired(err[2]), .startupError(err[3]), .upLinkUp(lnk[0]),
      .upRxActive(lnk[1]), .downLinkUp(lnk[2]), .downRxActive(lnk[3]),
      .cyclicFrame(cF), .mailboxFrame(mF), .runInd(obs[0]), .faultInd(obs[1]),
      .upLinkInd(obs[2]), .downLinkInd(obs[3]), .portSpeed(spd), .portFullDuplex(fd),
      .upIsMasterSide(ms), .cyclicUpdate(cU), .mailboxService(mS), .appCycleTick(aT));
   task automatic chk(input string nm, input int e, input int g);
      check_count++;
      if (e != g) begin
         error_cnt++;
         $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   // lit cycles and transitions over one full pattern sequence
   task automatic meas(input int s, input int p);
      int on, ed;
      logic pv;
      repeat (8) @(negedge ref_clk);
      on = 0;
      ed = 0;
      pv = obs[s];
      repeat (W) begin
         @(negedge ref_clk);
         on += int'(obs[s] === 1'b1);
         ed += int'(obs[s] !== pv);
         pv = obs[s];
      end
      chk($sformatf("indicator %0d lit", s), pOn[p], on);
      chk($sformatf("indicator %0d edges", s), pEd[p], ed);
   endtask
   task automatic t_const();
      logic [3:0] exp;
      exp = {status_ind_pkg::LINK_SPEED_100M, status_ind_pkg::LINK_FULL_DUP, 1'b1};
      @(negedge ref_clk);
      check_count++;
      if ({spd, fd, ms} !== exp) begin
         error_cnt++;
         $display("ERROR link setup expected %h seen %h", exp, {spd, fd, ms});
      end
   endtask
   // application ticks over ten local cycles, each one clock wide
   task automatic t_app();
      int n, wide;
      logic pv;
      n = 0;
      wide = 0;
      @(negedge ref_clk);
      pv = aT;
      repeat (10 * status_ind_pkg::APP_CYCLE_MS * TK) begin
         @(negedge ref_clk);
         n += int'(aT === 1'b1);
         wide += int'(aT === 1'b1 && pv === 1'b1);
         pv = aT;
      end
      chk("app cycle ticks", 10, n);
      chk("app tick width", 0, wide);
   endtask
   task automatic t_run();
      int rp[8] = '{0, 0, 2, 4, 1, 3, 0, 0};
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         st <= 3'(i);
         meas(0, rp[i]);
      end
   endtask
   task automatic t_fault();
      int e[7] = '{0, 1, 2, 4, 8, 15, 6};
      int fp[7] = '{0, 2, 4, 5, 3, 3, 5};
      for (int i = 0; i < 7; i++) begin
         @(posedge ref_clk);
         err <= 4'(e[i]);
         meas(1, fp[i]);
      end
   endtask
   task automatic t_port();
      int lc[3] = '{0, 1, 3};
      int pp[3] = '{0, 1, 3};
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         lnk <= {2'(lc[(i + 1) % 3]), 2'(lc[i])};
         meas(2, pp[i]);
         meas(3, pp[(i + 1) % 3]);
      end
   endtask
   task automatic t_strobe();
      int nc, nu, nm, ns;
      for (int i = 0; i < 3; i++) begin
         nc = 0;
         nu = 0;
         nm = 0;
         ns = 0;
         @(posedge ref_clk);
         per <= (i == 0) ? 4'h1 : 4'h9;
         coll <= (i == 2);
         run <= 1'b1;
         repeat (200) begin
            @(negedge ref_clk);
            nu += int'(cU === 1'b1);
            ns += int'(mS === 1'b1);
            nc += int'(cF === 1'b1);
            nm += int'(mF === 1'b1 && cF !== 1'b1);
         end
         @(posedge ref_clk);
         run <= 1'b0;
         @(negedge ref_clk);
         nu += int'(cU === 1'b1);
         ns += int'(mS === 1'b1);
         repeat (4) @(posedge ref_clk);
         chk("cyclic updates", nc, nu);
         chk("mailbox services", nm, ns);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_const();
      t_app();
      t_strobe();
      t_run();
      t_fault();
      t_port();
      end_sim();
   end
   initial begin
      #(100 * 95_000);
      error_cnt++;
      end_sim();
   end
endmodule
`default_nettype wire
